// ===== hw/bitstream_host.sv
// host-side framer and parser of the compressed field bitstream
// requests come in as field, block, data and end; the framer turns
// them into words for the codec, packing a three-byte carry so the
// entropy data lands right after the bin width. the parser watches
// the codec output while it encodes.
`timescale 1ns/100ps
`include "stream_defines.svh"
module bitstream_host #(
  parameter int BLOCKS_PER_FIELD = `BLOCKS_PER_FIELD
) (
  input logic clk,
  input logic rstn,
  input logic cmd_valid,
  input stream_pkg::cmd_s cmd,
  input logic [95:0] time_code,
  output logic cmd_ready_q,
  output logic [31:0] tx_word_q,
  output logic tx_valid_q,
  input logic tx_ready,
  output logic tx_field_err,
  input logic [31:0] rx_word,
  input logic rx_valid,
  output logic evt_valid_q,
  output stream_pkg::evt_s evt_q,
  output logic [95:0] rx_time_code,
  output logic rx_field_err
);
  import stream_pkg::*;

  fsm_e state_q;
  cmd_s cur_q;
  logic [2:0] idx_q;
  logic flush_q;
  logic pend_q;
  logic [23:0] carry_q;
  logic [95:0] tc_q;
  logic take;
  logic drop;
  logic slot_free;
  logic emit;
  logic last;
  logic head_done;
  logic rx_field_p;
  logic rx_block_p;
  logic rx_end_p;

  // last word index of each request kind
  function automatic logic [2:0] last_idx(op_e op);
    case (op)
      OP_FIELD: last_idx = `FIELD_LAST_IDX;
      OP_END: last_idx = `END_LAST_IDX;
      default: last_idx = `ONE_LAST_IDX;
    endcase
  endfunction

  // word at a given index of a request; data rides behind the carry
  function automatic logic [31:0] word_at(cmd_s c, logic [2:0] i,
                                          logic [95:0] tc,
                                          logic [23:0] cy);
    case (c.op)
      OP_FIELD: begin
        case (i)
          3'h0: word_at = `DELIM_WORD;
          3'h1: begin
            word_at = {c.field_two ? `FIELD_TWO_CODE : `FIELD_ONE_CODE,
                       `FIELD_TAIL};
          end
          3'h2: word_at = tc[95:64];
          3'h3: word_at = tc[63:32];
          default: word_at = tc[31:0];
        endcase
      end
      OP_BLOCK: word_at = `DELIM_WORD;
      OP_END: begin
        if (i == 3'h0) begin
          word_at = `DELIM_WORD;
        end else begin
          word_at = {`SEQ_END_CODE, `SEQ_END_TAIL};
        end
      end
      default: word_at = {cy, c.data[31:24]};
    endcase
  endfunction

  // type code byte and bin width that open the carry of a block
  function automatic logic [23:0] block_head(cmd_s c);
    if (c.zero) begin
      block_head = {`ZERO_BLOCK_CODE, `ZERO_BIN_WIDTH};
    end else begin
      block_head = {8'(`BLOCK_CODE_BASE + {6'h00, c.model}),
                    c.bin_width};
    end
  endfunction

  // data outside an open block has nowhere to go, so it is eaten
  assign take = cmd_valid && cmd_ready_q && state_q == S_IDLE;
  assign drop = cmd.op == OP_DATA && !pend_q;
  // the output word may be refilled once the codec has taken it
  assign slot_free = !tx_valid_q || tx_ready;
  assign emit = state_q == S_EMIT && slot_free;
  assign last = !flush_q && idx_q == last_idx(cur_q.op);
  assign head_done = emit && last;

  // request sequencing: one request at a time, ready only when idle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      cur_q <= '0;
      idx_q <= 3'h0;
      flush_q <= 1'b0;
      cmd_ready_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          cmd_ready_q <= 1'b1;
          if (take && !drop) begin
            state_q <= S_EMIT;
            cur_q <= cmd;
            idx_q <= 3'h0;
            cmd_ready_q <= 1'b0;
            // a new header first closes the open block's data
            flush_q <= pend_q && cmd.op != OP_DATA;
          end
        end
        S_EMIT: begin
          if (emit) begin
            if (flush_q) begin
              flush_q <= 1'b0;
            end else if (last) begin
              state_q <= S_IDLE;
              cmd_ready_q <= 1'b1;
            end else begin
              idx_q <= 3'(idx_q + 3'h1);
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
          cmd_ready_q <= 1'b0;
        end
      endcase
    end
  end

  // time code is latched with the field request, all 96 bits sent
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tc_q <= '0;
    end else if (take && cmd.op == OP_FIELD) begin
      tc_q <= time_code;
    end
  end

  // output word register; it holds still while the codec stalls
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_word_q <= '0;
      tx_valid_q <= 1'b0;
    end else if (emit) begin
      if (flush_q) begin
        tx_word_q <= {carry_q, `PAD_BYTE};
      end else begin
        tx_word_q <= word_at(cur_q, idx_q, tc_q, carry_q);
      end
      tx_valid_q <= 1'b1;
    end else if (tx_ready) begin
      tx_valid_q <= 1'b0;
    end
  end

  // three-byte carry: header tail first, then the low data bytes;
  // headers are 23 or 7 bytes, so every block lands three bytes in
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      carry_q <= '0;
      pend_q <= 1'b0;
    end else if (emit && flush_q) begin
      pend_q <= 1'b0;
    end else if (head_done) begin
      case (cur_q.op)
        OP_FIELD: begin
          // first block of a field carries subband block six
          carry_q <= {`FIELD_TYPE_CODE, cur_q.bin_width};
          pend_q <= 1'b1;
        end
        OP_BLOCK: begin
          carry_q <= block_head(cur_q);
          pend_q <= 1'b1;
        end
        OP_DATA: carry_q <= cur_q.data[23:0];
        default: pend_q <= 1'b0;
      endcase
    end
  end

  // block count of the outgoing fields, closed by the next field or the sequence end
  field_block_check #(
    .BLOCKS(BLOCKS_PER_FIELD),
    .W(6)
  ) u_tx_check (
    .clk(clk),
    .rstn(rstn),
    .field_start(head_done && cur_q.op == OP_FIELD),
    .block_start(head_done && cur_q.op == OP_BLOCK),
    .seq_end(head_done && cur_q.op == OP_END),
    .count_q(),
    .open_q(),
    .err_q(tx_field_err)
  );

  // codec output while encoding, up to and including its sequence end code
  stream_parser u_parser (
    .clk(clk),
    .rstn(rstn),
    .rx_word(rx_word),
    .rx_valid(rx_valid),
    .evt_valid_q(evt_valid_q),
    .evt_q(evt_q),
    .time_code(rx_time_code),
    .field_p(rx_field_p),
    .block_p(rx_block_p),
    .end_p(rx_end_p)
  );

  // block count of the incoming fields
  field_block_check #(
    .BLOCKS(BLOCKS_PER_FIELD),
    .W(6)
  ) u_rx_check (
    .clk(clk),
    .rstn(rstn),
    .field_start(rx_field_p),
    .block_start(rx_block_p),
    .seq_end(rx_end_p),
    .count_q(),
    .open_q(),
    .err_q(rx_field_err)
  );

  property p_delim_first;
    @(posedge clk) disable iff (!rstn)
      (emit && !flush_q && idx_q == 3'h0 && cur_q.op != OP_DATA) |=>
        tx_valid_q && tx_word_q == `DELIM_WORD;
  endproperty
  a_delim_first: assert property (p_delim_first)
    else $error("header did not open with the all-ones word");

  property p_field_code;
    @(posedge clk) disable iff (!rstn)
      (emit && !flush_q && cur_q.op == OP_FIELD && idx_q == 3'h1) |=>
        tx_word_q[31:25] == 7'h20 &&
        tx_word_q[24] == $past(cur_q.field_two) &&
        tx_word_q[23:0] == `FIELD_TAIL;
  endproperty
  a_field_code: assert property (p_field_code)
    else $error("field start code does not match the field");

  property p_seq_end;
    @(posedge clk) disable iff (!rstn)
      (emit && !flush_q && cur_q.op == OP_END && idx_q == 3'h1) |=>
        tx_word_q == {`SEQ_END_CODE, `SEQ_END_TAIL};
  endproperty
  a_seq_end: assert property (p_seq_end)
    else $error("sequence end code malformed");

  property p_pad_ones;
    @(posedge clk) disable iff (!rstn)
      (emit && flush_q) |=> tx_word_q[7:0] == `PAD_BYTE && !pend_q;
  endproperty
  a_pad_ones: assert property (p_pad_ones)
    else $error("block data not closed with ones");

  property p_hold_word;
    @(posedge clk) disable iff (!rstn)
      (tx_valid_q && !tx_ready) |=> tx_valid_q && $stable(tx_word_q);
  endproperty
  a_hold_word: assert property (p_hold_word)
    else $error("output word changed while stalled");

  property p_zero_head;
    @(posedge clk) disable iff (!rstn)
      (head_done && cur_q.op == OP_BLOCK && cur_q.zero) |=>
        carry_q == {`ZERO_BLOCK_CODE, `ZERO_BIN_WIDTH} && pend_q;
  endproperty
  a_zero_head: assert property (p_zero_head)
    else $error("zero block header not loaded");
endmodule

// ===== hw/stream_defines.svh
// codes, field layouts and counts of the compressed field bitstream
`ifndef STREAM_DEFINES_SVH
`define STREAM_DEFINES_SVH

// all-ones word that opens every delimiter
`define DELIM_WORD 32'hffff_ffff
// leading byte of the second delimiter word
`define FIELD_ONE_CODE 8'h40
`define FIELD_TWO_CODE 8'h41
`define BLOCK_CODE_BASE 8'h81
`define ZERO_BLOCK_CODE 8'h8f
`define SEQ_END_CODE 8'hc0
// rest of the second delimiter word
`define FIELD_TAIL 24'h00_0000
`define SEQ_END_TAIL 24'hff_ffff
// type code of the first subband block of a field
`define FIELD_TYPE_CODE 8'h84
// filler byte that closes the entropy data of a block
`define PAD_BYTE 8'hff
// bin width carried by a zero block
`define ZERO_BIN_WIDTH 16'h0000
// subband blocks after the field header block
`define BLOCKS_PER_FIELD 6'h29
// time code words and last word index of each header
`define TIME_WORDS 2'h3
`define FIELD_LAST_IDX 3'h4
`define END_LAST_IDX 3'h1
`define ONE_LAST_IDX 3'h0

`endif

// ===== hw/stream_pkg.sv
// types shared by the bitstream host framer and parser
package stream_pkg;

  // request kinds, also used to report parsed delimiters
  typedef enum logic [1:0] {
    OP_FIELD = 2'b00,
    OP_BLOCK = 2'b01,
    OP_DATA = 2'b10,
    OP_END = 2'b11
  } op_e;

  // framer states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EMIT = 2'b01
  } fsm_e;

  // parser states
  typedef enum logic [1:0] {
    P_SCAN = 2'b00,
    P_TIME = 2'b01,
    P_HEAD = 2'b10
  } parse_e;

  // one request to the framer
  typedef struct packed {
    op_e op;
    logic field_two;
    logic [1:0] model;
    logic zero;
    logic [15:0] bin_width;
    logic [31:0] data;
  } cmd_s;

  // one parsed header
  typedef struct packed {
    op_e kind;
    logic field_two;
    logic [7:0] code;
    logic [15:0] bin_width;
  } evt_s;

endpackage

// ===== hw/field_block_check.sv
// per-field subband block counter with a closing check
`timescale 1ns/100ps
`include "stream_defines.svh"
module field_block_check #(
  parameter int BLOCKS = `BLOCKS_PER_FIELD,
  parameter int W = 6
) (
  input logic clk,
  input logic rstn,
  input logic field_start,
  input logic block_start,
  input logic seq_end,
  output logic [W-1:0] count_q,
  output logic open_q,
  output logic err_q
);
  logic close;

  generate
    if (BLOCKS < 1 || BLOCKS >= (1 << W)) begin : g_bad
      $error("block count does not fit the counter");
    end
  endgenerate

  // a field closes on the next field start or the sequence end
  assign close = field_start || seq_end;

  // saturating count so a runaway stream never wraps to a good value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
      open_q <= 1'b0;
    end else if (close) begin
      count_q <= '0;
      open_q <= field_start;
    end else if (block_start && count_q != '1) begin
      count_q <= W'(count_q + 1'b1);
    end
  end

  // one-cycle pulse: short or long field, or block outside a field
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_q <= 1'b0;
    end else begin
      err_q <= (close && open_q && count_q != W'(BLOCKS)) ||
               (block_start && !close && !open_q);
    end
  end

  property p_short_field;
    @(posedge clk) disable iff (!rstn)
      (close && open_q && count_q != W'(BLOCKS)) |=> err_q;
  endproperty
  a_short_field: assert property (p_short_field)
    else $error("field closed with wrong block count, no error");

  property p_field_restart;
    @(posedge clk) disable iff (!rstn)
      field_start |=> (count_q == '0) && open_q;
  endproperty
  a_field_restart: assert property (p_field_restart)
    else $error("field start did not restart the block count");
endmodule

// ===== hw/stream_parser.sv
// parser of the stream that the codec emits while encoding
`timescale 1ns/100ps
`include "stream_defines.svh"
module stream_parser (
  input logic clk,
  input logic rstn,
  input logic [31:0] rx_word,
  input logic rx_valid,
  output logic evt_valid_q,
  output stream_pkg::evt_s evt_q,
  output logic [95:0] time_code,
  output logic field_p,
  output logic block_p,
  output logic end_p
);
  import stream_pkg::*;

  parse_e pst_q;
  logic seen_q;
  logic [1:0] tidx_q;
  logic [31:0] tcw_q [3];
  logic [2:0] cls;
  logic hit;

  // {known, kind} of a leading byte after an all-ones word
  function automatic logic [2:0] classify(logic [7:0] b);
    case (b)
      `FIELD_ONE_CODE, `FIELD_TWO_CODE: classify = {1'b1, OP_FIELD};
      `BLOCK_CODE_BASE, `BLOCK_CODE_BASE + 8'h01,
      `BLOCK_CODE_BASE + 8'h02, `BLOCK_CODE_BASE + 8'h03,
      `ZERO_BLOCK_CODE: classify = {1'b1, OP_BLOCK};
      `SEQ_END_CODE: classify = {1'b1, OP_END};
      default: classify = 3'h0;
    endcase
  endfunction

  // only aligned words are looked at, so a match is a delimiter
  assign cls = classify(rx_word[31:24]);
  assign hit = rx_valid && pst_q == P_SCAN && seen_q && cls[2];
  assign field_p = hit && op_e'(cls[1:0]) == OP_FIELD;
  assign block_p = hit && op_e'(cls[1:0]) == OP_BLOCK;
  assign end_p = hit && op_e'(cls[1:0]) == OP_END;
  assign time_code = {tcw_q[0], tcw_q[1], tcw_q[2]};

  // header walk; the host never stalls the codec output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pst_q <= P_SCAN;
      seen_q <= 1'b0;
      tidx_q <= 2'h0;
      evt_valid_q <= 1'b0;
      evt_q <= '0;
    end else begin
      evt_valid_q <= 1'b0;
      if (rx_valid) begin
        seen_q <= pst_q == P_SCAN && rx_word == `DELIM_WORD;
        case (pst_q)
          P_SCAN: if (hit) begin
            evt_q.kind <= op_e'(cls[1:0]);
            evt_q.field_two <= rx_word[31:24] == `FIELD_TWO_CODE;
            evt_q.code <= rx_word[31:24];
            evt_q.bin_width <= `ZERO_BIN_WIDTH;
            tidx_q <= 2'h0;
            if (field_p) begin
              pst_q <= P_TIME;
            end else begin
              // a block's bin width shares the word with its code byte
              if (block_p && rx_word[31:24] != `ZERO_BLOCK_CODE) begin
                evt_q.bin_width <= rx_word[23:8];
              end
              evt_valid_q <= 1'b1;
            end
          end
          P_TIME: begin
            tidx_q <= 2'(tidx_q + 2'h1);
            if (tidx_q == `TIME_WORDS - 2'h1) begin
              pst_q <= P_HEAD;
            end
          end
          P_HEAD: begin
            if (evt_q.kind == OP_FIELD) begin
              evt_q.code <= rx_word[31:24];
            end
            evt_q.bin_width <= rx_word[23:8];
            evt_valid_q <= 1'b1;
            pst_q <= P_SCAN;
          end
          default: pst_q <= P_SCAN;
        endcase
      end
    end
  end

  // time code words stored by index as they pass
  always_ff @(posedge clk) begin
    if (rx_valid && pst_q == P_TIME) begin
      tcw_q[tidx_q] <= rx_word;
    end
  end

  property p_head_event;
    @(posedge clk) disable iff (!rstn)
      (rx_valid && pst_q == P_HEAD) |=>
        evt_valid_q && evt_q.bin_width == $past(rx_word[23:8]);
  endproperty
  a_head_event: assert property (p_head_event)
    else $error("bin width not reported from header word");

  property p_zero_width;
    @(posedge clk) disable iff (!rstn)
      (evt_valid_q && evt_q.code == `ZERO_BLOCK_CODE) |->
        evt_q.bin_width == `ZERO_BIN_WIDTH;
  endproperty
  a_zero_width: assert property (p_zero_width)
    else $error("zero block reported a bin width");

  property p_needs_ones;
    @(posedge clk) disable iff (!rstn)
      (rx_valid && pst_q == P_SCAN && !seen_q) |=> pst_q == P_SCAN;
  endproperty
  a_needs_ones: assert property (p_needs_ones)
    else $error("header taken without an all-ones word");
endmodule

// ===== test/codec_model.sv
// behavioural codec model on the far side of the host framer
`timescale 1ns/100ps
module codec_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic [31:0] tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [31:0] rx_word,
  output logic rx_valid
);
  logic [31:0] got[$];
  logic ones_q;
  logic field_two_q;
  int restarts = 0;

  // released encode lines show the inverse of the last word
  initial begin
    rx_valid = 1'b0;
    rx_word = 32'h0;
  end

  // takes decode words; a slow codec stalls every other cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
      ones_q <= 1'b0;
      field_two_q <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_word);
        // delimiters are only looked for at word positions
        ones_q <= (tx_word == 32'hffff_ffff);
        // any known code restarts entropy decoding
        if (ones_q && tx_word[31:24] inside
            {8'h40, 8'h41, [8'h81:8'h84], 8'h8f, 8'hc0}) begin
          restarts = restarts + 1;
          if (tx_word[31:25] == 7'h20) begin
            field_two_q <= tx_word[24];
          end
        end
      end
    end
  end

  // one encode word per call, back to back allowed
  task automatic send_rx(input logic [31:0] w);
    @(posedge clk);
    rx_word <= w;
    rx_valid <= 1'b1;
  endtask

  // release the encode lines
  task automatic idle_rx();
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_word <= ~rx_word;
  endtask
endmodule

// ===== test/bitstream_host_test.sv
// self-checking bench of the host framer and parser
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", what, exp, got); end end
module bitstream_host_test;
  import stream_pkg::*;
  localparam int NBLK = 3;
  localparam logic [95:0] TC = 96'h0123_4567_89ab_cdef_0011_2233;
  typedef struct packed {
    cmd_s c;
    logic [3:0] n;
  } row_s;
  // requests beside the number of words each should add
  localparam row_s ROWS [13] = '{
    '{'{OP_FIELD, 1'b0, 2'h0, 1'b0, 16'h1234, 32'h0}, 4'h5},
    '{'{OP_DATA, 1'b0, 2'h0, 1'b0, 16'h0, 32'haabb_ccdd}, 4'h1},
    '{'{OP_BLOCK, 1'b0, 2'h2, 1'b0, 16'h0c2e, 32'h0}, 4'h2},
    '{'{OP_DATA, 1'b0, 2'h0, 1'b0, 16'h0, 32'h1122_3344}, 4'h1},
    '{'{OP_BLOCK, 1'b0, 2'h0, 1'b1, 16'hbeef, 32'h0}, 4'h2},
    '{'{OP_BLOCK, 1'b0, 2'h0, 1'b0, 16'h009a, 32'h0}, 4'h2},
    '{'{OP_END, 1'b0, 2'h0, 1'b0, 16'h0, 32'h0}, 4'h3},
    '{'{OP_DATA, 1'b0, 2'h0, 1'b0, 16'h0, 32'h5566_7788}, 4'h0},
    '{'{OP_FIELD, 1'b1, 2'h0, 1'b0, 16'h0000, 32'h0}, 4'h5},
    '{'{OP_BLOCK, 1'b0, 2'h1, 1'b0, 16'h007f, 32'h0}, 4'h2},
    '{'{OP_BLOCK, 1'b0, 2'h3, 1'b0, 16'ha417, 32'h0}, 4'h2},
    '{'{OP_FIELD, 1'b0, 2'h0, 1'b0, 16'h0001, 32'h0}, 4'h6},
    '{'{OP_END, 1'b0, 2'h0, 1'b0, 16'h0, 32'h0}, 4'h3}};
  localparam logic [31:0] RXW [16] = '{32'hffff_ffff, 32'h4100_0000,
    32'h0123_4567, 32'h89ab_cdef, 32'h0011_2233, 32'h831d_dcff,
    32'h1234_5678, 32'hffff_ffff, 32'h8f00_0000, 32'hffff_ffff,
    32'h8200_beff, 32'haaaa_aaaa, 32'hffff_ffff, 32'h7f00_0000,
    32'hffff_ffff, 32'hc0ff_ffff};
  localparam logic [7:0] EV_CODE [4] = '{8'h83, 8'h8f, 8'h82, 8'hc0};
  localparam op_e EV_KIND [4] = '{OP_FIELD, OP_BLOCK, OP_BLOCK, OP_END};
  localparam logic [15:0] EV_BW [3] = '{16'h1ddc, 16'h0000, 16'h00be};

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_s cmd = '0;
  logic slow = 1'b0;
  logic cmd_ready_q, tx_valid_q, tx_ready, tx_field_err;
  logic rx_valid, evt_valid_q, rx_field_err;
  logic [31:0] tx_word_q, rx_word;
  logic [95:0] rx_time_code;
  evt_s evt_q;
  evt_s evts[$];
  logic [31:0] exp_w[$];
  logic [23:0] carry = 24'h0;
  logic open_b = 1'b0;
  int err_total = 0;
  int checked = 0;
  int tx_errs = 0;
  int rx_errs = 0;
  int total = 0;

  always #12.5 clk = ~clk;

  bitstream_host #(.BLOCKS_PER_FIELD(NBLK)) DUT (
    .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
    .time_code(TC), .cmd_ready_q(cmd_ready_q), .tx_word_q(tx_word_q),
    .tx_valid_q(tx_valid_q), .tx_ready(tx_ready),
    .tx_field_err(tx_field_err), .rx_word(rx_word), .rx_valid(rx_valid),
    .evt_valid_q(evt_valid_q), .evt_q(evt_q),
    .rx_time_code(rx_time_code), .rx_field_err(rx_field_err));

  codec_model codec (
    .clk(clk), .rstn(rstn), .slow(slow), .tx_word(tx_word_q),
    .tx_valid(tx_valid_q), .tx_ready(tx_ready), .rx_word(rx_word),
    .rx_valid(rx_valid));

  // pulses and parsed headers, counted as they come
  always @(posedge clk) begin
    if (tx_field_err === 1'b1) tx_errs++;
    if (rx_field_err === 1'b1) rx_errs++;
    if (evt_valid_q === 1'b1) evts.push_back(evt_q);
  end

  // words a request should produce, carry kept as the host packs it
  task automatic expect_cmd(input cmd_s c);
    if (c.op != OP_DATA && open_b) exp_w.push_back({carry, 8'hff});
    case (c.op)
      OP_FIELD: begin
        exp_w.push_back(32'hffff_ffff);
        exp_w.push_back({7'h20, c.field_two, 24'h00_0000});
        exp_w.push_back(TC[95:64]);
        exp_w.push_back(TC[63:32]);
        exp_w.push_back(TC[31:0]);
        carry = {8'h84, c.bin_width};
        open_b = 1'b1;
      end
      OP_BLOCK: begin
        exp_w.push_back(32'hffff_ffff);
        carry = c.zero ? 24'h8f_0000 : {8'h81 + {6'h00, c.model},
          c.bin_width};
        open_b = 1'b1;
      end
      OP_DATA: begin
        if (open_b) begin
          exp_w.push_back({carry, c.data[31:24]});
          carry = c.data[23:0];
        end
      end
      default: begin
        exp_w.push_back(32'hffff_ffff);
        exp_w.push_back(32'hc0ff_ffff);
        open_b = 1'b0;
      end
    endcase
  endtask

  // wait for ready, offer one request, drop it once taken
  task automatic send_cmd(input cmd_s c);
    int i;
    i = 0;
    do begin @(posedge clk); #1; i++; end while (!cmd_ready_q && i < 200);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  // bounded wait until the framer is idle and its output taken
  task automatic drain();
    int i;
    i = 0;
    do begin @(posedge clk); #1; i++; end
      while (!(cmd_ready_q === 1'b1 && tx_valid_q === 1'b0) && i < 400);
  endtask

  task automatic finish_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // the run is a few hundred cycles; this is far beyond it
  initial begin
    #(25 * 20000);
    err_total++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    `CHK("ready in reset", 1'b0, cmd_ready_q)
    `CHK("tx valid in reset", 1'b0, tx_valid_q)
    `CHK("evt in reset", 1'b0, evt_valid_q)
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("ready after reset", 1'b1, cmd_ready_q)
    // same rows with a prompt codec, then with a stalling one
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      slow <= p[0];
      for (int r = 0; r < 13; r++) begin
        send_cmd(ROWS[r].c);
        expect_cmd(ROWS[r].c);
        drain();
        total += ROWS[r].n;
        `CHK("word count", total, codec.got.size())
        if (r == 8) `CHK("codec field two", 1'b1, codec.field_two_q)
      end
    end
    foreach (exp_w[k]) `CHK("tx word", exp_w[k], codec.got[k])
    `CHK("tx field errors", 4, tx_errs)
    // encode stream: field two, zero block, block, bad code, end
    foreach (RXW[k]) codec.send_rx(RXW[k]);
    codec.idle_rx();
    repeat (4) @(posedge clk);
    #1;
    `CHK("evt count", 4, evts.size())
    foreach (EV_CODE[k]) begin
      `CHK("evt code", EV_CODE[k], evts[k].code)
      `CHK("evt kind", EV_KIND[k], evts[k].kind)
      if (k < 3) `CHK("evt bin width", EV_BW[k], evts[k].bin_width)
    end
    `CHK("evt field two", 1'b1, evts[0].field_two)
    `CHK("rx time code", TC, rx_time_code)
    `CHK("rx field errors", 1, rx_errs)
    // second reset in mid-run with a block left open; no flush word
    // may survive it into the next header
    send_cmd(ROWS[0].c);
    drain();
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("ready in second reset", 1'b0, cmd_ready_q)
    `CHK("tx valid in second reset", 1'b0, tx_valid_q)
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("ready after second reset", 1'b1, cmd_ready_q)
    send_cmd(ROWS[12].c);
    drain();
    `CHK("words after reset", total + 7, codec.got.size())
    `CHK("end delimiter", 32'hffff_ffff, codec.got[total + 5])
    `CHK("end code", 32'hc0ff_ffff, codec.got[total + 6])
    `CHK("tx field errors after reset", 4, tx_errs)
    `CHK("codec restarts", 22, codec.restarts)
    finish_test();
  end
endmodule
